// >>> shared/supply_monitor_pkg.sv
// constants and types for the supply monitor flag logic
package supply_monitor_pkg;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h8;
  localparam logic [31:0] CONTROL_BASE = 32'hFFFF0440;
  localparam int BIT_FLAG = 0;
  localparam int BIT_ON = 1;
  localparam int BIT_TRIP = 2;
  localparam int BIT_STATUS = 3;
  localparam logic [15:0] CONTROL_RESET = 16'h0008;
  localparam logic [2:0] IRQ_RESET = 3'h0;
  localparam int TRIP_MV_0 = 2790;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK = 2'b01
  } bus_state_t;
endpackage

// >>> shared/supply_sync_if.sv
// interface carrying the raw and synchronised comparator level
`timescale 1ns/100ps
`default_nettype none
interface supply_sync_if;
  logic raw_level;
  logic sync_level;
  modport sync (input raw_level, output sync_level);
  modport user (output raw_level, input sync_level);
endinterface
`default_nettype wire

// >>> src/level_sync.sv
// two-flop synchroniser for the comparator level
`timescale 1ns/100ps
`default_nettype none
module level_sync
(
  input wire logic clk_sys,
  input wire logic rst,
  supply_sync_if.sync port_s
);
  logic stage1;
  logic stage2;
  // reset to 1: matches status reset value, no false flag at start
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      stage1 <= 1'b1;
      stage2 <= 1'b1;
    end
    else
    begin
      stage1 <= port_s.raw_level;
      stage2 <= stage1;
    end
  end
  assign port_s.sync_level = stage2;
endmodule // level_sync
`default_nettype wire

// >>> src/supply_monitor_flag_logic.sv
// supply monitor control/status register with avalon slave and interrupt
//
// The implementer's own choice: register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none
module supply_monitor_flag_logic
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [supply_monitor_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic comparator_above,
  output logic supply_monitor_on,
  output logic trip_select,
  output logic low_supply_irq
);
  import supply_monitor_pkg::*;

  // ********************************
  // comparator synchronisation
  // ********************************
  supply_sync_if sync_bus ();
  logic supply_above_trip;
  logic above_prev;
  logic fall_event;
  logic rise_event;

  // powered-down monitor reads as above trip
  assign sync_bus.raw_level = comparator_above | ~supply_monitor_on;

  level_sync u_sync
  (
    .clk_sys(clk_sys),
    .rst(rst),
    .port_s(sync_bus.sync)
  );

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      supply_above_trip <= CONTROL_RESET[BIT_STATUS];
      above_prev <= CONTROL_RESET[BIT_STATUS];
    end
    else
    begin
      supply_above_trip <= sync_bus.sync_level;
      above_prev <= supply_above_trip;
    end
  end

  assign fall_event = above_prev & ~supply_above_trip;
  assign rise_event = ~above_prev & supply_above_trip;

  // ********************************
  // avalon slave
  // ********************************
  bus_state_t bus_state;
  logic access_go;
  logic wr_go;
  logic rd_go;
  logic lane0;

  // one wait cycle, answer on second edge
  assign access_go = (bus_state == BUS_ACK);
  assign wr_go = access_go & avs_write;
  assign rd_go = access_go & avs_read;
  assign lane0 = avs_byteenable[0];

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      bus_state <= BUS_IDLE;
      avs_waitrequest <= 1'b1;
    end
    else
    begin
      case (bus_state)
        BUS_IDLE:
        begin
          if (avs_read | avs_write)
          begin
            bus_state <= BUS_ACK;
            avs_waitrequest <= 1'b0;
          end
        end
        BUS_ACK:
        begin
          bus_state <= BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default:
        begin
          bus_state <= BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // ********************************
  // control register
  // ********************************
  logic low_supply_flag;
  logic flag_clear_req;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      supply_monitor_on <= CONTROL_RESET[BIT_ON];
      trip_select <= CONTROL_RESET[BIT_TRIP];
    end
    else if (wr_go && lane0 && avs_address == OFS_CONTROL)
    begin
      supply_monitor_on <= avs_writedata[BIT_ON];
      trip_select <= avs_writedata[BIT_TRIP];
    end
  end

  assign flag_clear_req = wr_go & lane0 & (avs_address == OFS_CONTROL)
    & avs_writedata[BIT_FLAG];

  // clear only with status high; a new fall beats the clear
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      low_supply_flag <= CONTROL_RESET[BIT_FLAG];
    else if (fall_event)
      low_supply_flag <= 1'b1;
    else if (flag_clear_req && supply_above_trip)
      low_supply_flag <= 1'b0;
  end

  // ********************************
  // interrupt status and mask
  // ********************************
  logic [2:0] irq_status;
  logic [2:0] irq_source_mask;
  logic [2:0] irq_events;
  logic status_read;

  // bit0 low supply flag level, bit1 fall event, bit2 recovery event
  assign irq_events = {rise_event, fall_event, low_supply_flag};
  assign status_read = rd_go & (avs_address == OFS_IRQ_STATUS);

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      irq_status <= IRQ_RESET;
    else if (status_read)
      irq_status <= irq_events; // set wins over read-clear
    else
      irq_status <= irq_status | irq_events;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      irq_source_mask <= IRQ_RESET;
    else if (wr_go && lane0 && avs_address == OFS_IRQ_MASK)
      irq_source_mask <= avs_writedata[2:0];
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      low_supply_irq <= 1'b0;
    else
      low_supply_irq <= |(irq_status & irq_source_mask);
  end

  // ********************************
  // read data
  // ********************************
  function automatic logic [31:0] read_mux(input logic [ADDR_W-1:0] a);
    case (a)
      OFS_CONTROL: read_mux = {28'h0000000, supply_above_trip, trip_select,
                               supply_monitor_on, low_supply_flag};
      OFS_IRQ_STATUS: read_mux = {29'h00000000, irq_status};
      OFS_IRQ_MASK: read_mux = {29'h00000000, irq_source_mask};
      default: read_mux = UNMAPPED_READ;
    endcase
  endfunction

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      avs_readdata <= 32'h0000_0000;
    else if (bus_state == BUS_IDLE && avs_read)
      avs_readdata <= read_mux(avs_address);
  end

endmodule // supply_monitor_flag_logic
`default_nettype wire

// >>> testbench/supply_monitor_flag_logic_monitor.sv
// assertions on the supply monitor register port
`timescale 1ns/100ps
`default_nettype none
module supply_monitor_flag_logic_monitor
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [supply_monitor_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic supply_monitor_on,
  input wire logic trip_select
);
  import supply_monitor_pkg::*;
  wire logic rd = avs_read && !avs_waitrequest;
  wire logic wr = avs_write && !avs_waitrequest && avs_address == OFS_CONTROL
    && avs_byteenable[0];
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_ack_one:
    assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest) else $error("late");
  a_ack_pulse:
    assert property (!avs_waitrequest |=> avs_waitrequest) else $error("long ack");
  a_on_write:
    assert property (wr |=> supply_monitor_on == $past(avs_writedata[1])) else $error("on");
  a_on_hold:
    assert property ($changed(supply_monitor_on) |-> $past(wr)) else $error("on moved");
  a_trip_write:
    assert property (wr |=> trip_select == $past(avs_writedata[2])) else $error("trip");
  a_trip_hold:
    assert property ($changed(trip_select) |-> $past(wr)) else $error("trip moved");
  a_ctrl_upper:
    assert property (rd && avs_address == OFS_CONTROL |-> avs_readdata[31:4] == '0) else $error("hi");
  a_unmapped_zero:
    assert property (rd && avs_address == 4'hC |-> avs_readdata == UNMAPPED_READ) else $error("gap");
endmodule // supply_monitor_flag_logic_monitor
bind supply_monitor_flag_logic supply_monitor_flag_logic_monitor mon (.*);
`default_nettype wire

// >>> testbench/test_supply_monitor_flag_logic.sv
// self-checking bench for the supply monitor flag logic
`timescale 1ns/100ps
`default_nettype none
`define chk(n, e, g) begin n_tests++; if ((g) !== (e)) begin \
  $display("wrong value %s expected %h seen %h", n, e, g); err_total++; end end
module test_supply_monitor_flag_logic;
  import supply_monitor_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic comparator_above = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic [31:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, supply_monitor_on, trip_select, low_supply_irq;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  supply_monitor_flag_logic dut (.*);
  initial
  begin
    forever #5 clk_sys = !clk_sys;
  end
  // request held until answered; ends off-edge so outputs have settled
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic expect_ctrl(input logic [31:0] e);
    bus(1'b0, OFS_CONTROL, '0);
    `chk("control", e, q)
  endtask
  // long enough for the synchroniser, flag and irq stages
  task automatic settle(input logic v);
    @(posedge clk_sys);
    comparator_above <= v;
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic reset_values;
    expect_ctrl(32'h8);
    `chk("on", 1'b0, supply_monitor_on)
    `chk("trip", 1'b0, trip_select)
  endtask
  task automatic control_bits;
    bus(1'b1, OFS_CONTROL, 32'h6);
    `chk("on", 1'b1, supply_monitor_on)
    `chk("trip", 1'b1, trip_select)
    expect_ctrl(32'hE);
    bus(1'b1, OFS_CONTROL, 32'h2);
    `chk("trip", 1'b0, trip_select)
    bus(1'b1, 4'hC, 32'hF);
    bus(1'b0, 4'hC, '0);
    `chk("gap", 32'h0, q)
  endtask
  task automatic low_flag;
    settle(1'b0);
    expect_ctrl(32'h3);
    `chk("irq", 1'b0, low_supply_irq)
    bus(1'b1, OFS_CONTROL, 32'h3);
    expect_ctrl(32'h3);
    settle(1'b1);
    bus(1'b1, OFS_CONTROL, 32'h2);
    expect_ctrl(32'hB);
    bus(1'b1, OFS_CONTROL, 32'h3);
    expect_ctrl(32'hA);
  endtask
  task automatic irq_path;
    bus(1'b1, OFS_IRQ_MASK, 32'h1);
    bus(1'b0, OFS_IRQ_STATUS, '0);
    `chk("irq status", 32'h7, q)
    settle(1'b0);
    `chk("irq", 1'b1, low_supply_irq)
    settle(1'b1);
    expect_ctrl(32'hB);
    bus(1'b1, OFS_CONTROL, 32'h3);
    bus(1'b0, OFS_IRQ_STATUS, '0);
    repeat (3) @(negedge clk_sys);
    `chk("irq", 1'b0, low_supply_irq)
  endtask
  task automatic monitor_off;
    bus(1'b1, OFS_CONTROL, 32'h0);
    settle(1'b0);
    expect_ctrl(32'h8);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      err_total++;
      finish_test;
    end
  end
  initial
  begin
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    reset_values;
    control_bits;
    low_flag;
    irq_path;
    monitor_off;
    finish_test;
  end
endmodule // test_supply_monitor_flag_logic
`default_nettype wire
